//--- src/osag_top.sv
// Operand access unit: operand stack, address formation, modes, APB registers
// What this block does
// R1: four-cell ring stack with one pointer
// R2: only the pointed cell is accessible
// R3: step after fetch, before deposit
// R4: fetch and deposit steps go opposite ways
// R5: tags 00 step, 01 hold, 1x memory
// R6: tag 10 plain, 11 indexed address
// R7: add up to three index registers
// R8: index selector zero means none
// R9: fifteen index, fifteen limit, 16-bit each
// R10: index contents unsigned, wrap subtracts
// R11: branch loads program base plus literal
// R12: eleven-bit displacement plus data base
// R13: direct reach is 2048 words
// R14: top syllable bit means indirect
// R15: continuation bit fetches again
// R16: chain unlimited until bit clear
// R17: address low sixteen, continuation above
// R18: indexing applied after chain resolves
// R19: snag bit beyond first level sets flag
// R20: syllables are twelve bits
// R21: operator syllable never indexed
// R22: interrupt taken only between operations
// R23: interrupt enters control mode
// R24: normal mode blocks privileged actions
// R25: power failure freezes sequencing, except an indirect fetch, and resumes state
// R26: address sums wrap at sixteen bits
// R27: tags processed first to third
`default_nettype none
`include "osag_defines.svh"
module osag_top
  import osag_pkg::*;
#(
  parameter int WW = 48,
  parameter int AW = 16
)(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Main memory read port for indirect words
  output logic               mem_req,
  output logic      [AW-1:0] mem_addr,
  input  wire logic          mem_ack,
  input  wire logic [WW-1:0] mem_rdata,
  // Result store permission and side pins
  output logic               res_store,
  output logic      [AW-1:0] res_addr,
  output logic               io_start,
  output logic               ctrl_mode,
  input  wire logic          ext_irq,
  input  wire logic          pwr_fail
);
  osag_state_t    st_r;
  logic [1:0]     k_r;
  logic           lvl_r;
  logic [AW-1:0]  maddr_r;
  osag_op_syl_t   op_r;
  osag_opnd_syl_t syl_r [3];
  logic [AW-1:0]  ea_r [3];
  logic [WW-1:0]  opnd_r [2];
  logic [AW-1:0]  bar_r, bpr_r, pwc_r, oslo_r, oshi_r;
  logic [AW-1:0]  xreg_r [1:15];
  logic [AW-1:0]  lim_r [1:15];
  logic [WW-1:0]  stkin_r;
  logic           irqen_r, cmode_r, snag_r, wblk_r, store_r, io_r;
  logic [31:0]    rd_r;
  logic [1:0]     pin_q [3];
  logic [1:0]     pin_r;

  // External pins: three stages, a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_q[0][gi] <= 1'b0;
          pin_q[1][gi] <= 1'b0;
          pin_q[2][gi] <= 1'b0;
          pin_r[gi]    <= 1'b0;
        end
        else
        begin
          pin_q[0][gi] <= (gi == 0) ? ext_irq : pwr_fail;
          pin_q[1][gi] <= pin_q[0][gi];
          pin_q[2][gi] <= pin_q[1][gi];
          if (pin_q[1][gi] == pin_q[2][gi])
            pin_r[gi] <= pin_q[2][gi];
        end
      end
    end
  endgenerate

  logic irq_s, pwr_s, run;
  assign irq_s = pin_r[0];
  assign pwr_s = pin_r[1];
  // The sequencer freezes outside indirect fetches while power is out; flops keep the state to resume from
  assign run   = !pwr_s;                                                 // [R25]

  // Index register lookup; selector zero contributes nothing
  function automatic logic [AW-1:0] xsel(input logic [3:0] s);
    xsel = (s == 4'h0) ? '0 : xreg_r[s];                                 // [R8] [R9]
  endfunction

  // Unsigned adds, silently wrapped to the address width
  function automatic logic [AW-1:0] idx_add(input logic [AW-1:0] b, input osag_idx_syl_t s);
    idx_add = AW'(b + xsel(s.s0) + xsel(s.s1) + xsel(s.s2));             // [R7] [R10] [R26]
  endfunction

  // APB decode
  logic wr, setup, cpriv;
  assign wr    = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign cpriv = cmode_r;
  assign pready = 1'b1;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:6] == `OSAG_XREG_SEL || a[7:6] == `OSAG_LIM_SEL) ? (a[5:2] != 4'h0)
           : (a <= `OSAG_A_TOP && a[1:0] == 2'h0);
  endfunction
  assign pslverr = psel && penable && !mapped(paddr);

  // Operand tag of the current slot, handled first to third
  logic [1:0]     tag;
  osag_opnd_syl_t cur;
  logic [AW-1:0]  ea1;
  always_comb
  begin
    case (k_r)
      2'h0:    tag = op_r.tag1;                                          // [R27]
      2'h1:    tag = op_r.tag2;
      default: tag = op_r.tag3;
    endcase
  end
  assign cur = syl_r[k_r];
  assign ea1 = AW'(bar_r + {5'h00, cur.adr.disp});                       // [R12] [R13] [R26]

  // Stack access in the decode cycle of a stack tag
  logic stk_op, stk_fetch, stk_dep;
  logic [WW-1:0] stk_top;
  logic [1:0]    stk_ptr;
  assign stk_op    = (st_r == S_NEXT) && run && !tag[1];                 // [R5]
  assign stk_fetch = stk_op && (k_r != `OSAG_LAST_OPND);
  assign stk_dep   = stk_op && (k_r == `OSAG_LAST_OPND);

  osag_stack #(.WW(WW)) u_stack (
    .pclk    (pclk),
    .presetn (presetn),
    .fetch   (stk_fetch),
    .deposit (stk_dep),
    .step    (stk_op && !tag[0]),                                        // [R5]
    .wdata   (stkin_r),
    .top     (stk_top),
    .ptr     (stk_ptr)
  );

  // Final address of a memory operand: indexing only once the chain ends
  logic          fin_vld;
  logic [AW-1:0] fin_base, fin_addr;
  logic          chain, snag_set, slot_done;
  always_comb
  begin
    fin_vld  = 1'b0;
    fin_base = ea1;
    case (st_r)
      S_NEXT:
      begin
        fin_vld  = run && tag[1] && !cur.adr.ind;                        // [R6]
        fin_base = ea1;
      end
      S_FETCH:
      begin
        fin_vld  = mem_ack && !mem_rdata[`OSAG_IND_CONT];                // [R16]
        fin_base = mem_rdata[AW-1:0];                                    // [R17]
      end
      default:
      begin
        fin_vld  = 1'b0;
        fin_base = ea1;
      end
    endcase
  end
  assign fin_addr  = tag[0] ? idx_add(fin_base, cur.idx) : fin_base;    // [R6] [R18]
  assign chain     = (st_r == S_FETCH) && mem_ack && mem_rdata[`OSAG_IND_CONT];
  assign snag_set  = (st_r == S_FETCH) && mem_ack && lvl_r && mem_rdata[`OSAG_IND_SNAG];
  assign slot_done = stk_op || fin_vld;
  assign mem_req   = (st_r == S_FETCH);
  assign mem_addr  = maddr_r;

  logic start_p, irq_take;
  assign start_p  = wr && paddr == `OSAG_A_CTRL && pwdata[`OSAG_CTRL_START];
  // Interrupt only between operations, and never when a new one starts
  assign irq_take = irq_s && irqen_r && st_r == S_IDLE && !start_p && run;  // [R22]

  // Sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r    <= S_IDLE;
      k_r     <= 2'h0;
      lvl_r   <= 1'b0;
      maddr_r <= '0;
    end
    else
    begin
      case (st_r)
        S_IDLE:
        begin
          k_r <= 2'h0;
          if (start_p && run)
            st_r <= S_NEXT;
        end
        S_NEXT:
        begin
          if (run && tag[1] && cur.adr.ind)
          begin
            maddr_r <= ea1;                                              // [R14]
            lvl_r   <= 1'b0;
            st_r    <= S_FETCH;
          end
        end
        S_FETCH:
        begin
          if (chain)
          begin
            maddr_r <= mem_rdata[AW-1:0];                                // [R15] [R17]
            lvl_r   <= 1'b1;
          end
        end
        default:
          st_r <= S_IDLE;
      endcase
      if (slot_done)
      begin
        if (k_r == `OSAG_LAST_OPND)
          st_r <= S_IDLE;
        else
        begin
          k_r  <= 2'(k_r + 2'h1);                                        // [R27]
          st_r <= S_NEXT;
        end
      end
    end
  end

  // Effective addresses and operands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 3; i++)
        ea_r[i] <= '0;
      opnd_r[0] <= '0;
      opnd_r[1] <= '0;
    end
    else
    begin
      if (fin_vld)
        ea_r[k_r] <= fin_addr;
      if (stk_fetch)
        opnd_r[k_r[0]] <= stk_top;                                       // [R2]
    end
  end

  // Result store gate: normal mode may not write the OS program area
  logic in_os;
  assign in_os = fin_addr >= oslo_r && fin_addr <= oshi_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      store_r <= 1'b0;
      io_r    <= 1'b0;
    end
    else
    begin
      store_r <= fin_vld && k_r == `OSAG_LAST_OPND && (cpriv || !in_os);  // [R24]
      io_r    <= wr && paddr == `OSAG_A_CTRL && pwdata[`OSAG_CTRL_IO] && cpriv;  // [R24]
    end
  end
  assign res_store = store_r;
  assign res_addr  = ea_r[`OSAG_LAST_OPND];
  assign io_start  = io_r;
  assign ctrl_mode = cmode_r;

  // Mode and sticky status; a hardware set wins over a software clear
  logic st_wr;
  assign st_wr = wr && paddr == `OSAG_A_STATUS;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmode_r <= `OSAG_CMODE_RST;
      irqen_r <= 1'b0;
      snag_r  <= 1'b0;
      wblk_r  <= 1'b0;
    end
    else
    begin
      if (irq_take)
        cmode_r <= 1'b1;                                                 // [R23]
      else if (st_wr && cpriv && !pwdata[`OSAG_ST_CMODE])
        cmode_r <= 1'b0;
      if (wr && paddr == `OSAG_A_CTRL && cpriv)
        irqen_r <= pwdata[`OSAG_CTRL_IRQEN];                             // [R24]
      if (snag_set)
        snag_r <= 1'b1;                                                  // [R19]
      else if (st_wr && pwdata[`OSAG_ST_SNAG])
        snag_r <= 1'b0;
      if (fin_vld && k_r == `OSAG_LAST_OPND && !cpriv && in_os)
        wblk_r <= 1'b1;                                                  // [R24]
      else if (st_wr && pwdata[`OSAG_ST_WBLK])
        wblk_r <= 1'b0;
    end
  end

  // Software-loaded configuration and syllables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_r    <= '0;
      bar_r   <= '0;
      bpr_r   <= '0;
      pwc_r   <= '0;
      oslo_r  <= '0;
      oshi_r  <= '0;
      stkin_r <= '0;
      for (int i = 0; i < 3; i++)
        syl_r[i] <= '0;
      for (int i = 1; i < 16; i++)
      begin
        xreg_r[i] <= '0;
        lim_r[i]  <= '0;
      end
    end
    else if (wr && st_r == S_IDLE)
    begin
      case (paddr)
        `OSAG_A_OPSYL:  op_r     <= pwdata[11:0];                        // [R20] [R21]
        `OSAG_A_SYL0:   syl_r[0] <= pwdata[23:0];                        // [R20]
        `OSAG_A_SYL1:   syl_r[1] <= pwdata[23:0];
        `OSAG_A_SYL2:   syl_r[2] <= pwdata[23:0];
        `OSAG_A_BAR:    bar_r    <= pwdata[AW-1:0];
        `OSAG_A_BPR:    bpr_r    <= pwdata[AW-1:0];
        `OSAG_A_BRANCH: pwc_r    <= AW'(bpr_r + {4'h0, pwdata[11:0]});   // [R11] [R26]
        `OSAG_A_STKIN:  stkin_r  <= {{(WW-32){1'b0}}, pwdata};
        `OSAG_A_OSLO:   if (cpriv) oslo_r <= pwdata[AW-1:0];             // [R24]
        `OSAG_A_OSHI:   if (cpriv) oshi_r <= pwdata[AW-1:0];             // [R24]
        default:
        begin
          if (paddr[7:6] == `OSAG_XREG_SEL && paddr[5:2] != 4'h0)
            xreg_r[paddr[5:2]] <= pwdata[AW-1:0];                        // [R9]
          else if (paddr[7:6] == `OSAG_LIM_SEL && paddr[5:2] != 4'h0)
            lim_r[paddr[5:2]] <= pwdata[AW-1:0];                         // [R9]
        end
      endcase
    end
  end

  // Read data is captured in the setup phase so it leaves a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_r <= 32'h0000_0000;
    else if (setup && !pwrite)
    begin
      case (paddr)
        `OSAG_A_CTRL:   rd_r <= {29'h0, irqen_r, 2'h0};
        `OSAG_A_STATUS: rd_r <= {27'h0, pwr_s, wblk_r, snag_r, cmode_r, st_r != S_IDLE};
        `OSAG_A_OPSYL:  rd_r <= {20'h0, op_r};
        `OSAG_A_SYL0:   rd_r <= {8'h0, syl_r[0]};
        `OSAG_A_SYL1:   rd_r <= {8'h0, syl_r[1]};
        `OSAG_A_SYL2:   rd_r <= {8'h0, syl_r[2]};
        `OSAG_A_BAR:    rd_r <= {16'h0, bar_r};
        `OSAG_A_BPR:    rd_r <= {16'h0, bpr_r};
        `OSAG_A_PWC:    rd_r <= {16'h0, pwc_r};
        `OSAG_A_STKIN:  rd_r <= stkin_r[31:0];
        `OSAG_A_EA0:    rd_r <= {16'h0, ea_r[0]};
        `OSAG_A_EA1:    rd_r <= {16'h0, ea_r[1]};
        `OSAG_A_EA2:    rd_r <= {16'h0, ea_r[2]};
        `OSAG_A_OPND0:  rd_r <= opnd_r[0][31:0];
        `OSAG_A_OPND1:  rd_r <= opnd_r[1][31:0];
        `OSAG_A_OSLO:   rd_r <= {16'h0, oslo_r};
        `OSAG_A_OSHI:   rd_r <= {16'h0, oshi_r};
        `OSAG_A_TOP:    rd_r <= {14'h0, stk_ptr, stk_top[15:0]};
        default:
        begin
          if (paddr[7:6] == `OSAG_XREG_SEL && paddr[5:2] != 4'h0)
            rd_r <= {16'h0, xreg_r[paddr[5:2]]};
          else if (paddr[7:6] == `OSAG_LIM_SEL && paddr[5:2] != 4'h0)
            rd_r <= {16'h0, lim_r[paddr[5:2]]};
          else
            rd_r <= 32'h0000_0000;
        end
      endcase
    end
  end
  assign prdata = rd_r;

  a_branch_load: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `OSAG_A_BRANCH && st_r == S_IDLE
    |=> pwc_r == AW'($past(bpr_r) + {4'h0, $past(pwdata[11:0])}))  // [R11]
    else $error("program word counter not loaded with base plus literal");
  a_ind_first: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == S_NEXT && run && tag[1] && cur.adr.ind |=> mem_req && mem_addr == $past(ea1))  // [R14]
    else $error("indirect fetch not issued at base plus displacement");
  a_chain_next: assert property (@(posedge pclk) disable iff (!presetn)
    chain |=> mem_req && mem_addr == $past(mem_rdata[AW-1:0]))  // [R15]
    else $error("continued chain did not fetch the new address");
  a_direct_ea: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == S_NEXT && run && tag == 2'h2 && !cur.adr.ind |=> ea_r[$past(k_r)] == $past(ea1))  // [R12]
    else $error("direct address is not base plus displacement");
  a_snag_flag: assert property (@(posedge pclk) disable iff (!presetn)
    snag_set |=> snag_r)  // [R19]
    else $error("snag word did not set the flag");
  a_irq_idle: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cmode_r) |-> $past(st_r) == S_IDLE && $past(irq_s))  // [R22]
    else $error("control mode entered during an operation");
  a_priv_block: assert property (@(posedge pclk) disable iff (!presetn)
    wr && !cmode_r && (paddr == `OSAG_A_OSLO || paddr == `OSAG_A_OSHI)
    |=> $stable(oslo_r) && $stable(oshi_r))  // [R24]
    else $error("normal mode changed the protected area bounds");
  a_pwr_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_s && st_r != S_FETCH |=> $stable(st_r) && $stable(k_r))  // [R25]
    else $error("sequencer advanced during power failure");
endmodule
`default_nettype wire

//--- src/osag_defines.svh
// Register offsets, field positions and reset values of the operand access unit
`ifndef OSAG_DEFINES_SVH
`define OSAG_DEFINES_SVH
`define OSAG_A_CTRL    8'h00
`define OSAG_A_STATUS  8'h04
`define OSAG_A_OPSYL   8'h08
`define OSAG_A_SYL0    8'h0C
`define OSAG_A_SYL1    8'h10
`define OSAG_A_SYL2    8'h14
`define OSAG_A_BAR     8'h18
`define OSAG_A_BPR     8'h1C
`define OSAG_A_PWC     8'h20
`define OSAG_A_BRANCH  8'h24
`define OSAG_A_STKIN   8'h28
`define OSAG_A_EA0     8'h2C
`define OSAG_A_EA1     8'h30
`define OSAG_A_EA2     8'h34
`define OSAG_A_OPND0   8'h38
`define OSAG_A_OPND1   8'h3C
`define OSAG_A_OSLO    8'h40
`define OSAG_A_OSHI    8'h44
`define OSAG_A_TOP     8'h48
`define OSAG_XREG_SEL  2'h2
`define OSAG_LIM_SEL   2'h3
`define OSAG_CTRL_START 0
`define OSAG_CTRL_IO    1
`define OSAG_CTRL_IRQEN 2
`define OSAG_ST_BUSY    0
`define OSAG_ST_CMODE   1
`define OSAG_ST_SNAG    2
`define OSAG_ST_WBLK    3
`define OSAG_ST_PWR     4
`define OSAG_IND_CONT   16
`define OSAG_IND_SNAG   17
`define OSAG_LAST_OPND  2'h2
`define OSAG_CMODE_RST  1'b1
`endif

//--- src/osag_pkg.sv
// Types shared by the operand access unit
`default_nettype none
package osag_pkg;
  typedef enum logic [1:0] {S_IDLE, S_NEXT, S_FETCH} osag_state_t;
  typedef struct packed {
    logic [5:0] opcode;
    logic [1:0] tag1;
    logic [1:0] tag2;
    logic [1:0] tag3;
  } osag_op_syl_t;
  typedef struct packed {
    logic        ind;
    logic [10:0] disp;
  } osag_addr_syl_t;
  typedef struct packed {
    logic [3:0] s2;
    logic [3:0] s1;
    logic [3:0] s0;
  } osag_idx_syl_t;
  typedef struct packed {
    osag_idx_syl_t  idx;
    osag_addr_syl_t adr;
  } osag_opnd_syl_t;
endpackage
`default_nettype wire

//--- src/osag_stack.sv
// Four-word circular operand stack with a ring pointer
`default_nettype none
module osag_stack
  import osag_pkg::*;
#(
  parameter int WW = 48
)(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Access
  input  wire logic          fetch,
  input  wire logic          deposit,
  input  wire logic          step,
  input  wire logic [WW-1:0] wdata,
  output logic      [WW-1:0] top,
  output logic      [1:0]    ptr
);
  logic [WW-1:0] cell_r [4];
  logic [1:0]    ptr_r;
  logic [1:0]    wptr;

  // A deposit steps clockwise first, a fetch steps back afterwards
  assign wptr = (deposit && step) ? 2'(ptr_r + 2'h1) : ptr_r;  // [R3] [R4]
  assign top  = cell_r[ptr_r];                                 // [R2]
  assign ptr  = ptr_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ptr_r <= 2'h0;
    else if (step && deposit)
      ptr_r <= 2'(ptr_r + 2'h1);                               // [R3]
    else if (step && fetch)
      ptr_r <= 2'(ptr_r - 2'h1);                               // [R4]
  end

  always_ff @(posedge pclk)
  begin
    if (deposit)
      cell_r[wptr] <= wdata;                                   // [R1] [R2]
  end

  a_stack_fetch_step: assert property (@(posedge pclk) disable iff (!presetn)
    fetch && step && !deposit |=> ptr == 2'($past(ptr) - 2'h1))  // [R3]
    else $error("stack pointer did not step back after fetch");
  a_stack_hold:       assert property (@(posedge pclk) disable iff (!presetn)
    !step |=> $stable(ptr))  // [R5]
    else $error("held stack pointer moved");
  a_stack_wr_rd:      assert property (@(posedge pclk) disable iff (!presetn)
    deposit && step |=> top == $past(wdata))  // [R4]
    else $error("fetch after deposit returned another cell");
endmodule
`default_nettype wire

//--- bench/osag_mem_model.sv
// Behavioural main memory answering indirect word fetches
`default_nettype none
module osag_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Fetch port
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_ack,
  output logic      [47:0] mem_rdata,
  // Latency choice
  input  wire logic        slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [47:0] cells [logic [15:0]];
  int          wait_n;

  task automatic load(input logic [15:0] a, input logic [47:0] w);
    cells[a] = w;
  endtask

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= '0;
      wait_n    <= 0;
    end
    else if (mem_req && !mem_ack && wait_n >= (slow ? 3 : 0))
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= cells.exists(mem_addr) ? cells[mem_addr] : {32'h0, ~mem_addr};
      wait_n    <= 0;
    end
    else
    begin
      // Data is only valid with the answer, so it keeps changing elsewhere
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_n    <= mem_req ? wait_n + 1 : 0;
    end
  end
endmodule
`default_nettype wire

//--- bench/osag_top_tb.sv
// Self-checking bench of the operand access unit
`default_nettype none
`include "osag_defines.svh"
module osag_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, mem_ack, ext_irq, pwr_fail;
  logic        pready, pslverr, mem_req, res_store, io_start, ctrl_mode, slow, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ien;
  logic [15:0] mem_addr, res_addr;
  logic [47:0] mem_rdata;
  int          n_errors, compares, cyc, n_store, n_io;

`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      n_errors++; \
      $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

  osag_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .res_store(res_store), .res_addr(res_addr),
    .io_start(io_start), .ctrl_mode(ctrl_mode), .ext_irq(ext_irq), .pwr_fail(pwr_fail));
  osag_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Pulse counters and the hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (res_store === 1'b1)
      n_store++;
    if (io_start === 1'b1)
      n_io++;
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end

  // One APB transfer followed by an idle cycle, so no signal is driven twice per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // The wait ends once pready is high; the bench timeout guards a hang
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic syl(input int n, input logic [11:0] x, input logic [11:0] a);
    wr(8'(`OSAG_A_SYL0 + 4 * n), {8'h0, x, a});
  endtask

  task automatic run(input logic [5:0] tags);
    wr(`OSAG_A_OPSYL, {26'h0, tags});
    wr(`OSAG_A_CTRL, ien | 32'h1);
    rdr(`OSAG_A_STATUS);
    while (rd[`OSAG_ST_BUSY] !== 1'b0)
      rdr(`OSAG_A_STATUS);
  endtask

  task automatic t_regs();
    `CHK("ctrl_mode", 1'b1, ctrl_mode)
    rdr(8'h80);
    `CHK("unmapped err", 1'b1, err)
    wr(8'hFC, 32'h0000_1234);
    rdr(8'hFC);
    `CHK("limit15", 32'h0000_1234, rd)
  endtask

  task automatic t_stack();
    wr(`OSAG_A_STKIN, 32'h1234_5678);
    run(6'b10_10_00);
    wr(`OSAG_A_STKIN, 32'hAAAA_5555);
    run(6'b10_10_00);
    rdr(`OSAG_A_TOP);
    `CHK("top", 32'h0002_5555, rd)
    run(6'b00_00_10);
    rdr(`OSAG_A_OPND0);
    `CHK("opnd0", 32'hAAAA_5555, rd)
    rdr(`OSAG_A_OPND1);
    `CHK("opnd1", 32'h1234_5678, rd)
    rdr(`OSAG_A_TOP);
    `CHK("ptr", 2'h0, rd[17:16])
    wr(`OSAG_A_STKIN, 32'h0000_BEEF);
    run(6'b10_10_01);
    run(6'b01_00_10);
    rdr(`OSAG_A_OPND0);
    `CHK("held", 32'h0000_BEEF, rd)
    rdr(`OSAG_A_OPND1);
    `CHK("stepped", 32'h0000_BEEF, rd)
    rdr(`OSAG_A_TOP);
    `CHK("ptr", 2'h3, rd[17:16])
  endtask

  task automatic t_direct();
    int s;
    s = n_store;
    wr(`OSAG_A_BAR, 32'hFFF0);
    wr(8'hBC, 32'hFFFE);
    wr(8'h88, 32'h0005);
    rdr(8'hBC);
    `CHK("index15", 32'h0000_FFFE, rd)
    syl(0, 12'h02F, 12'h004);
    syl(1, 12'h000, 12'h7FF);
    syl(2, 12'h000, 12'h010);
    run(6'b11_11_10);
    rdr(`OSAG_A_EA0);
    `CHK("ea0", 32'h0000_FFF7, rd)
    rdr(`OSAG_A_EA1);
    `CHK("ea1", 32'h0000_07EF, rd)
    rdr(`OSAG_A_EA2);
    `CHK("ea2", 32'h0000_0000, rd)
    `CHK("res_addr", 16'h0000, res_addr)
    `CHK("stores", s + 1, n_store)
  endtask

  // Indirect chains; the far memory answers slowly here
  task automatic t_indirect();
    wr(`OSAG_A_BAR, 32'h0100);
    wr(8'h84, 32'h0010);
    mem.load(16'h0103, {30'h0, 1'b1, 1'b1, 16'h2000});
    mem.load(16'h2000, {30'h0, 1'b0, 1'b0, 16'h3000});
    syl(0, 12'h001, 12'h803);
    slow <= 1'b1;
    run(6'b11_10_10);
    rdr(`OSAG_A_EA0);
    `CHK("ea0 chain", 32'h0000_3010, rd)
    rdr(`OSAG_A_STATUS);
    `CHK("snag first", 1'b0, rd[`OSAG_ST_SNAG])
    mem.load(16'h2000, {30'h0, 1'b1, 1'b1, 16'h4000});
    mem.load(16'h4000, {30'h0, 1'b0, 1'b0, 16'h0444});
    run(6'b11_10_10);
    slow <= 1'b0;
    rdr(`OSAG_A_EA0);
    `CHK("ea0 deep", 32'h0000_0454, rd)
    rdr(`OSAG_A_STATUS);
    `CHK("snag later", 1'b1, rd[`OSAG_ST_SNAG])
  endtask

  task automatic t_branch(input logic [15:0] b, input logic [11:0] l, input logic [15:0] e);
    wr(`OSAG_A_BPR, {16'h0, b});
    wr(`OSAG_A_BRANCH, {20'h0, l});
    rdr(`OSAG_A_PWC);
    `CHK("pwc", {16'h0, e}, rd)
  endtask

  task automatic t_modes();
    int s;
    int i;
    wr(`OSAG_A_OSLO, 32'h0100);
    wr(`OSAG_A_OSHI, 32'h01FF);
    i = n_io;
    ien = 32'h4;
    wr(`OSAG_A_CTRL, 32'h6);
    repeat (2) @(posedge pclk);
    `CHK("io ctrl", i + 1, n_io)
    wr(`OSAG_A_STATUS, 32'h0);
    `CHK("ctrl_mode", 1'b0, ctrl_mode)
    wr(`OSAG_A_OSLO, 32'h0);
    rdr(`OSAG_A_OSLO);
    `CHK("oslo", 32'h0100, rd)
    wr(`OSAG_A_CTRL, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK("io normal", i + 1, n_io)
    s = n_store;
    syl(2, 12'h000, 12'h050);
    run(6'b10_10_10);
    `CHK("blocked", s, n_store)
    rdr(`OSAG_A_STATUS);
    `CHK("wblk", 1'b1, rd[`OSAG_ST_WBLK])
    syl(2, 12'h000, 12'h200);
    run(6'b10_10_10);
    `CHK("allowed", s + 1, n_store)
    ext_irq <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("irq entry", 1'b1, ctrl_mode)
    ext_irq <= 1'b0;
  endtask

  // A start during power failure must leave the sequencer idle
  task automatic t_power();
    pwr_fail <= 1'b1;
    repeat (6) @(posedge pclk);
    wr(`OSAG_A_CTRL, 32'h1);
    rdr(`OSAG_A_STATUS);
    `CHK("pwr flag", 1'b1, rd[`OSAG_ST_PWR])
    `CHK("pwr frozen", 1'b0, rd[`OSAG_ST_BUSY])
    pwr_fail <= 1'b0;
    repeat (6) @(posedge pclk);
    rdr(`OSAG_A_STATUS);
    `CHK("pwr back", 1'b0, rd[`OSAG_ST_PWR])
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, ext_irq, pwr_fail, slow} = '0;
    {paddr, pwdata, ien} = '0;
    {n_errors, compares, cyc, n_store, n_io} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_stack();
    t_direct();
    t_indirect();
    t_branch(16'h1000, 12'hFFF, 16'h1FFF);
    t_branch(16'hFFFF, 12'h001, 16'h0000);
    t_modes();
    t_power();
    complete_run();
  end
endmodule
`default_nettype wire
